// [verilog/pattern_consts.svh]
// constants for the pattern next-data register bank
`ifndef PATTERN_CONSTS_SVH
`define PATTERN_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_UPPER_NEXT_PAIR 16'hFFA4
`define IDX_LOWER_NEXT_PAIR 16'hFFA5
`define IDX_UPPER_NEXT_ALT 16'hFFA6
`define IDX_LOWER_NEXT_ALT 16'hFFA7
`define IDX_TRIGGER_SELECT 16'hFFA1
`define IDX_UPPER_ENABLE 16'hFFA2
`define IDX_LOWER_ENABLE 16'hFFA3
`define IDX_LOWER_PORT_DATA 16'hFFD3
`define IDX_UPPER_PORT_DATA 16'hFFD6

// address widths
`define ADDR_W 18
`define IDX_LSB 2

// reset values
`define NEXT_PATTERN_RESET 8'h00
`define NEXT_ENABLE_RESET 8'h00
`define PORT_DATA_RESET 8'h00
`define TRIGGER_SELECT_RESET 8'hFF

// reserved bits read as one
`define RESERVED_NIBBLE 4'hF
`define RESERVED_BYTE 8'hFF

// trigger select field positions
`define SEL_G0_LSB 0
`define SEL_G1_LSB 2
`define SEL_G2_LSB 4
`define SEL_G3_LSB 6
`define SEL_FIELD_W 2

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verilog/pattern_pkg.sv]
// types for the pattern next-data register bank
package pattern_pkg;

  typedef struct packed {
    logic aw_have;
    logic [15:0] aw_idx;
    logic w_have;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] lower_port_output_data;
    logic [7:0] upper_port_output_data;
    logic [7:0] lower_next_enable;
    logic [7:0] upper_next_enable;
    logic [7:0] trigger_select_register;
    logic [7:0] lower_next_pattern;
    logic [7:0] upper_next_pattern;
  } state_t;

  typedef logic [15:0] reg_index_t;

endpackage

// [verilog/group_trigger.sv]
// per-group trigger selection from timer compare-match events
`timescale 1ns/1ps
`include "pattern_consts.svh"

module group_trigger (
  input wire logic [7:0] trigger_select,
  input wire logic [3:0] compare_match,
  output logic [3:0] group_fire
);
  import pattern_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_group
      logic [1:0] sel;
      assign sel = trigger_select[g*`SEL_FIELD_W +: `SEL_FIELD_W];
      // codes 00..11 pick channel 0..3 [RULE_16]
      assign group_fire[g] = compare_match[sel]; // [RULE_16]
    end
  endgenerate

endmodule // group_trigger

// [verilog/pulse_pattern_next_data.sv]
// next-pattern staging and port output data registers, axi4-lite slave
//
// Operation
// RULE_01 - upper port data: 8-bit read/write, holds groups 2 and 3, reset zero.
// RULE_02 - upper port data bits with enable set ignore software writes.
// RULE_03 - lower next pattern copied to enabled lower port bits on trigger.
// RULE_04 - lower next pattern cleared by reset and hardware standby only.
// RULE_05 - shared lower trigger: whole lower next pattern at first address.
// RULE_06 - shared lower trigger: companion address reads all ones, ignores writes.
// RULE_07 - split lower trigger: group 1 nibble first address, group 0 second.
// RULE_08 - split lower trigger: unused nibbles read one and ignore writes.
// RULE_09 - upper next pattern copied to enabled upper port bits on trigger.
// RULE_10 - upper next pattern cleared by reset and hardware standby only.
// RULE_11 - shared upper trigger: whole upper next pattern at first address.
// RULE_12 - shared upper trigger: companion address reads all ones, ignores writes.
// RULE_13 - split upper trigger: group 3 nibble first address, group 2 second.
// RULE_14 - split upper trigger: unused nibbles read one and ignore writes.
// RULE_15 - bits with enable clear are not copied; output holds.
// RULE_16 - 2-bit select per group picks channel 0..3; select resets to 0xFF.
// RULE_17 - shared or split decided live by comparing the pair's select fields.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pattern_consts.svh"

module pulse_pattern_next_data (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic [3:0] compare_match,
  output logic [15:0] pattern_out,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import pattern_pkg::*;

  localparam state_t RESET_STATE = '{
    bresp: `RESP_OKAY,
    rresp: `RESP_OKAY,
    lower_port_output_data: `PORT_DATA_RESET,
    upper_port_output_data: `PORT_DATA_RESET,
    lower_next_enable: `NEXT_ENABLE_RESET,
    upper_next_enable: `NEXT_ENABLE_RESET,
    trigger_select_register: `TRIGGER_SELECT_RESET,
    lower_next_pattern: `NEXT_PATTERN_RESET,
    upper_next_pattern: `NEXT_PATTERN_RESET,
    default: '0
  };

  state_t state_reg;
  state_t state_next;
  logic [3:0] group_fire;
  logic shared_lower;
  logic shared_upper;
  logic [7:0] lower_fire_mask;
  logic [7:0] upper_fire_mask;

  group_trigger trig_sel (
    .trigger_select(state_reg.trigger_select_register),
    .compare_match(compare_match),
    .group_fire(group_fire)
  );

  // pair mode follows the select fields directly, no extra state [RULE_17]
  assign shared_lower = state_reg.trigger_select_register[3:2] ==
                        state_reg.trigger_select_register[1:0]; // [RULE_17]
  assign shared_upper = state_reg.trigger_select_register[7:6] ==
                        state_reg.trigger_select_register[5:4]; // [RULE_17]

  assign lower_fire_mask = {{4{group_fire[1]}}, {4{group_fire[0]}}};
  assign upper_fire_mask = {{4{group_fire[3]}}, {4{group_fire[2]}}};

  // read decode: {hit, value}
  function automatic logic [8:0] read_value(input reg_index_t idx,
                                            input state_t s,
                                            input logic sh_lo,
                                            input logic sh_hi);
    logic [8:0] r;
    r = {1'b0, 8'h00};
    unique case (idx)
      `IDX_LOWER_NEXT_PAIR: begin
        if (sh_lo) begin
          r = {1'b1, s.lower_next_pattern}; // [RULE_05]
        end else begin
          // low nibble reserved in split mode [RULE_08]
          r = {1'b1, s.lower_next_pattern[7:4], `RESERVED_NIBBLE}; // [RULE_07]
        end
      end
      `IDX_LOWER_NEXT_ALT: begin
        if (sh_lo) begin
          r = {1'b1, `RESERVED_BYTE}; // [RULE_06]
        end else begin
          r = {1'b1, `RESERVED_NIBBLE, s.lower_next_pattern[3:0]}; // [RULE_08]
        end
      end
      `IDX_UPPER_NEXT_PAIR: begin
        if (sh_hi) begin
          r = {1'b1, s.upper_next_pattern}; // [RULE_11]
        end else begin
          r = {1'b1, s.upper_next_pattern[7:4], `RESERVED_NIBBLE}; // [RULE_14]
        end
      end
      `IDX_UPPER_NEXT_ALT: begin
        if (sh_hi) begin
          r = {1'b1, `RESERVED_BYTE}; // [RULE_12]
        end else begin
          r = {1'b1, `RESERVED_NIBBLE, s.upper_next_pattern[3:0]}; // [RULE_13]
        end
      end
      `IDX_TRIGGER_SELECT: r = {1'b1, s.trigger_select_register};
      `IDX_UPPER_ENABLE: r = {1'b1, s.upper_next_enable};
      `IDX_LOWER_ENABLE: r = {1'b1, s.lower_next_enable};
      `IDX_LOWER_PORT_DATA: r = {1'b1, s.lower_port_output_data};
      `IDX_UPPER_PORT_DATA: r = {1'b1, s.upper_port_output_data}; // [RULE_01]
      default: r = {1'b0, 8'h00};
    endcase
    return r;
  endfunction

  always_comb begin
    logic aw_take;
    logic w_take;
    logic aw_ok;
    logic w_ok;
    logic do_write;
    logic hit;
    logic [15:0] widx;
    logic [7:0] wd;
    logic [8:0] rv;
    aw_take = 1'b0;
    w_take = 1'b0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    do_write = 1'b0;
    hit = 1'b0;
    widx = 16'h0000;
    wd = 8'h00;
    rv = 9'h000;
    state_next = state_reg;

    // write channel; address and data may come in either order
    aw_take = awvalid && !state_reg.aw_have && !state_reg.bvalid;
    w_take = wvalid && !state_reg.w_have && !state_reg.bvalid;
    aw_ok = state_reg.aw_have || aw_take;
    w_ok = state_reg.w_have || w_take;
    widx = state_reg.aw_have ? state_reg.aw_idx :
           awaddr[`ADDR_W-1:`IDX_LSB];
    wd = state_reg.w_have ? state_reg.w_data : wdata[7:0];
    if (aw_take) begin
      state_next.aw_have = 1'b1;
      state_next.aw_idx = awaddr[`ADDR_W-1:`IDX_LSB];
    end
    if (w_take) begin
      state_next.w_have = 1'b1;
      state_next.w_data = wdata[7:0];
      state_next.w_lane0 = wstrb[0];
    end
    do_write = aw_ok && w_ok && !state_reg.bvalid;
    if (do_write) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      rv = read_value(widx, state_reg, shared_lower, shared_upper);
      hit = rv[8];
      state_next.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
      // byte lane 0 carries the 8-bit register; other lanes dropped
      if (hit && (state_reg.w_have ? state_reg.w_lane0 : wstrb[0])) begin
        unique case (widx)
          `IDX_LOWER_NEXT_PAIR: begin
            if (shared_lower) begin
              state_next.lower_next_pattern = wd; // [RULE_05]
            end else begin
              state_next.lower_next_pattern[7:4] = wd[7:4]; // [RULE_07]
            end
          end
          `IDX_LOWER_NEXT_ALT: begin
            // whole byte reserved when shared [RULE_06]
            if (!shared_lower) begin
              state_next.lower_next_pattern[3:0] = wd[3:0]; // [RULE_08]
            end
          end
          `IDX_UPPER_NEXT_PAIR: begin
            if (shared_upper) begin
              state_next.upper_next_pattern = wd; // [RULE_11]
            end else begin
              state_next.upper_next_pattern[7:4] = wd[7:4]; // [RULE_13]
            end
          end
          `IDX_UPPER_NEXT_ALT: begin
            if (!shared_upper) begin
              state_next.upper_next_pattern[3:0] = wd[3:0]; // [RULE_14]
            end
          end
          `IDX_TRIGGER_SELECT: state_next.trigger_select_register = wd;
          `IDX_UPPER_ENABLE: state_next.upper_next_enable = wd;
          `IDX_LOWER_ENABLE: state_next.lower_next_enable = wd;
          `IDX_LOWER_PORT_DATA: begin
            state_next.lower_port_output_data =
              (state_reg.lower_port_output_data &
               state_reg.lower_next_enable) |
              (wd & ~state_reg.lower_next_enable);
          end
          `IDX_UPPER_PORT_DATA: begin
            // enabled bits are driven by the pattern, so locked [RULE_02]
            state_next.upper_port_output_data =
              (state_reg.upper_port_output_data &
               state_reg.upper_next_enable) |
              (wd & ~state_reg.upper_next_enable); // [RULE_01]
          end
          default: state_next.bresp = `RESP_SLVERR;
        endcase
      end
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end

    // read channel
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && !state_reg.rvalid) begin
      rv = read_value(araddr[`ADDR_W-1:`IDX_LSB], state_reg,
                      shared_lower, shared_upper);
      state_next.rvalid = 1'b1;
      state_next.rdata = rv[7:0];
      state_next.rresp = rv[8] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // trigger copy; software cannot touch enabled bits, so no overlap
    state_next.lower_port_output_data =
      (state_next.lower_port_output_data &
       ~(lower_fire_mask & state_reg.lower_next_enable)) |
      (state_reg.lower_next_pattern & lower_fire_mask &
       state_reg.lower_next_enable); // [RULE_03] [RULE_15]
    state_next.upper_port_output_data =
      (state_next.upper_port_output_data &
       ~(upper_fire_mask & state_reg.upper_next_enable)) |
      (state_reg.upper_next_pattern & upper_fire_mask &
       state_reg.upper_next_enable); // [RULE_09] [RULE_15]

    // software standby has no port here: contents simply persist
    if (hw_standby) begin
      state_next.lower_next_pattern = `NEXT_PATTERN_RESET; // [RULE_04]
      state_next.upper_next_pattern = `NEXT_PATTERN_RESET; // [RULE_10]
      state_next.lower_next_enable = `NEXT_ENABLE_RESET;
      state_next.upper_next_enable = `NEXT_ENABLE_RESET;
      state_next.trigger_select_register = `TRIGGER_SELECT_RESET; // [RULE_16]
      state_next.lower_port_output_data = `PORT_DATA_RESET;
      state_next.upper_port_output_data = `PORT_DATA_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RESET_STATE; // [RULE_01] [RULE_04] [RULE_10] [RULE_16]
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready = !state_reg.aw_have && !state_reg.bvalid;
  assign wready = !state_reg.w_have && !state_reg.bvalid;
  assign arready = !state_reg.rvalid;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign rvalid = state_reg.rvalid;
  assign rresp = state_reg.rresp;
  assign rdata = {24'h000000, state_reg.rdata};
  assign pattern_out = {state_reg.upper_port_output_data,
                        state_reg.lower_port_output_data};

endmodule // pulse_pattern_next_data

// [verification/pulse_pattern_chk.sv]
// bus and output checker for the next-pattern register bank
`timescale 1ns/1ps
`include "pattern_consts.svh"
module pulse_pattern_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hw_standby,
  input wire logic [3:0] compare_match,
  input wire logic [15:0] pattern_out,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> bvalid)
    else $error("no write response after both channels taken");
  a_read_answer: assert property (s_rd_take |=> rvalid ##0
    rdata[31:8] == 24'h000000) else $error("read answer missing or wide");
  a_resp_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata)) else $error("read data dropped");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_read_block: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  // outputs move only on a trigger, a write or a standby clear
  a_out_quiet: assert property (compare_match == 4'h0 &&
    !(awvalid && awready) && !(wvalid && wready) && !hw_standby
    |=> $stable(pattern_out)) else $error("output moved without cause");
  a_standby_clear: assert property (hw_standby |=>
    pattern_out == 16'h0000) else $error("standby left output set");
endmodule // pulse_pattern_chk
bind pulse_pattern_next_data pulse_pattern_chk i_chk (.aclk, .aresetn,
  .hw_standby, .compare_match, .pattern_out, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready,
  .rdata);

// [verification/timer_model.sv]
// timer unit stand-in issuing one-cycle compare-match pulses
`timescale 1ns/1ps
module timer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] fire_req,
  output logic [3:0] compare_match
);
  // pulses are one cycle; a held level would fire every cycle
  always_ff @(posedge aclk) begin
    compare_match <= aresetn ? fire_req : 4'h0;
  end
endmodule // timer_model

// [verification/pulse_pattern_next_data_tb.sv]
// self-checking bench for the next-pattern register bank
`timescale 1ns/1ps
`include "pattern_consts.svh"
module pulse_pattern_next_data_tb;
  logic aclk, aresetn, hw_standby, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] wstrb, fire_req, compare_match;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] pattern_out;
  logic [33:0] exp_q[$];
  logic [7:0] nu, nl, eu, el, sel, pu, pl, v;
  int n_fail, checked, cyc;
  pulse_pattern_next_data i_dut (.aclk, .aresetn, .hw_standby,
    .compare_match, .pattern_out, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp);
  timer_model i_timer (.aclk, .aresetn, .fire_req, .compare_match);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
    if (bvalid === 1'b1 && bready === 1'b1)
      chk("write", {bresp, 32'h00000000}, exp_q.pop_front());
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk("read", {rresp, rdata}, exp_q.pop_front());
      chk("pattern_out", 34'(pattern_out), 34'({pu, pl}));
    end
  end
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] rs = `RESP_OKAY,
                    input logic [3:0] st = 4'hF);
    @(posedge aclk);
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    awaddr <= {idx, 2'b00}; wdata <= {24'h000000, d}; wstrb <= st;
    exp_q.push_back({rs, 32'h00000000});
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] rs = `RESP_OKAY);
    @(posedge aclk);
    arvalid <= 1'b1; rready <= 1'b1; araddr <= {idx, 2'b00};
    exp_q.push_back({rs, 24'h000000, d});
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  function automatic logic [3:0] fired(logic [7:0] s, logic [3:0] cm);
    for (int g = 0; g < 4; g++) fired[g] = cm[s[2*g +: 2]];
  endfunction
  // model copies enabled bits of each fired group, others hold
  task automatic trig(input int c);
    logic [3:0] f;
    logic [7:0] m;
    f = fired(sel, 4'(1 << c));
    @(posedge aclk) fire_req <= 4'(1 << c);
    @(posedge aclk) fire_req <= 4'h0;
    repeat (2) @(posedge aclk);
    m = {{4{f[1]}}, {4{f[0]}}} & el;
    pl = (pl & ~m) | (nl & m);
    m = {{4{f[3]}}, {4{f[2]}}} & eu;
    pu = (pu & ~m) | (nu & m);
  endtask
  task automatic ports();
    rd(`IDX_LOWER_PORT_DATA, pl);
    rd(`IDX_UPPER_PORT_DATA, pu);
  endtask
  initial begin
    void'($urandom(32'hE9191F17));
    {aresetn, hw_standby, awvalid, wvalid, bready, arvalid, rready} = '0;
    fire_req = 4'h0; wstrb = 4'h0; awaddr = '0; araddr = '0; wdata = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    {nu, nl, eu, el, pu, pl} = '0;
    sel = `TRIGGER_SELECT_RESET;
    rd(`IDX_TRIGGER_SELECT, 8'hFF);
    rd(`IDX_UPPER_NEXT_PAIR, 8'h00);
    rd(`IDX_LOWER_NEXT_PAIR, 8'h00);
    rd(`IDX_UPPER_PORT_DATA, 8'h00);
    // lane 0 strobe low: no store, still okay
    wr(`IDX_UPPER_NEXT_PAIR, 8'hFF, `RESP_OKAY, 4'hE);
    rd(`IDX_UPPER_NEXT_PAIR, 8'h00);
    wr(16'hFFA0, 8'h00, `RESP_SLVERR);
    nu = 8'($urandom); nl = 8'($urandom);
    eu = 8'($urandom); el = 8'($urandom);
    wr(`IDX_UPPER_NEXT_PAIR, nu); wr(`IDX_LOWER_NEXT_PAIR, nl);
    wr(`IDX_UPPER_NEXT_ALT, 8'h5A); wr(`IDX_LOWER_NEXT_ALT, 8'hA5);
    wr(`IDX_UPPER_ENABLE, eu); wr(`IDX_LOWER_ENABLE, el);
    rd(`IDX_UPPER_NEXT_PAIR, nu);
    rd(`IDX_UPPER_NEXT_ALT, 8'hFF);
    rd(`IDX_LOWER_NEXT_PAIR, nl);
    rd(`IDX_LOWER_NEXT_ALT, 8'hFF);
    for (int c = 0; c < 4; c++) begin
      trig(c);
      ports();
    end
    // enabled bits are locked against software writes
    v = 8'($urandom);
    wr(`IDX_UPPER_PORT_DATA, v);
    pu = (pu & eu) | (v & ~eu);
    wr(`IDX_LOWER_PORT_DATA, ~v);
    pl = (pl & el) | (~v & ~el);
    ports();
    sel = 8'h1B;
    wr(`IDX_TRIGGER_SELECT, sel);
    rd(`IDX_UPPER_NEXT_PAIR, {nu[7:4], 4'hF});
    rd(`IDX_UPPER_NEXT_ALT, {4'hF, nu[3:0]});
    rd(`IDX_LOWER_NEXT_PAIR, {nl[7:4], 4'hF});
    rd(`IDX_LOWER_NEXT_ALT, {4'hF, nl[3:0]});
    v = 8'($urandom);
    wr(`IDX_UPPER_NEXT_ALT, v); wr(`IDX_LOWER_NEXT_ALT, ~v);
    // split mode: first address must not reach the low nibble
    wr(`IDX_UPPER_NEXT_PAIR, ~v); wr(`IDX_LOWER_NEXT_PAIR, v);
    nu = {~v[7:4], v[3:0]}; nl = {v[7:4], ~v[3:0]};
    rd(`IDX_UPPER_NEXT_ALT, {4'hF, nu[3:0]});
    rd(`IDX_UPPER_NEXT_PAIR, {nu[7:4], 4'hF});
    rd(`IDX_LOWER_NEXT_ALT, {4'hF, nl[3:0]});
    rd(`IDX_LOWER_NEXT_PAIR, {nl[7:4], 4'hF});
    for (int c = 0; c < 4; c++) begin
      trig(c);
      ports();
    end
    rd(16'hFFA0, 8'h00, `RESP_SLVERR);
    @(posedge aclk) hw_standby <= 1'b1;
    @(posedge aclk) hw_standby <= 1'b0;
    {nu, nl, eu, el, pu, pl} = '0;
    rd(`IDX_UPPER_NEXT_PAIR, 8'h00);
    rd(`IDX_LOWER_NEXT_PAIR, 8'h00);
    rd(`IDX_TRIGGER_SELECT, 8'hFF);
    complete_run();
  end
endmodule // pulse_pattern_next_data_tb
